// File: design/dac_setting_defines.svh
// Purpose: Constants for the serial setting port and its power-up handling
// Assumes: 50 MHz sampling clock
// Notes:   Times are in ns, rates in kb/s
`ifndef DAC_SETTING_DEFINES_SVH
`define DAC_SETTING_DEFINES_SVH

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SHIFT_DEFAULT    8'h40
`define SETTING_DEFAULT  7'h20

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SLAVE_ADDR_DEFAULT 7'h2E
`define CMD_SETTING      8'h00
`define BYTE_BITS        4'h8
`define SETTING_WIDTH    7
`define SHIFT_WIDTH      8

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS    20
`define SPIKE_NS         50
`define SPIKE_CYCLES     ((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STD_RATE_KBPS    100
`define FAST_RATE_KBPS   400
`define FAST_BIT_CYCLES  (1000000 / (`FAST_RATE_KBPS * `CLK_PERIOD_NS))

`endif

// File: design/dac_setting_pkg.sv
// Purpose: Types for the serial setting port
// Assumes: Nothing
// Notes:   Constants live in the defines header
package dac_setting_pkg;

    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_CMD,
        BUS_CMD_ACK,
        BUS_WDATA,
        BUS_WDATA_ACK,
        BUS_RDATA,
        BUS_RDATA_ACK,
        BUS_IGNORE
    } bus_state_type;

endpackage

// File: design/glitch_filter.sv
// Purpose: Two-flop synchroniser and spike filter for one pin
// Assumes: Pin is asynchronous to ref_clk
// Notes:   Level follows the pin once it has been stable for LEN cycles
`timescale 1ns/10ps
module glitch_filter #(
    parameter int   LEN  = 3,
    parameter logic INIT = 1'b1
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic pin,
    output logic      level
);

    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_M1 = CW'(LEN - 1);

    if (LEN < 2) begin : g_bad_len
        $error("glitch_filter: LEN must be at least 2");
    end

    logic          sync1_reg;
    logic          sync2_reg;
    logic          level_reg;
    logic [CW-1:0] cnt_reg;
    wire           agree = (sync2_reg == level_reg);
    wire           ripe  = (cnt_reg == LEN_M1);

    // ----------------------------------------
    // Sync and filter
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_reg <= INIT;
            sync2_reg <= INIT;
            level_reg <= INIT;
            cnt_reg   <= '0;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
            if (agree || ripe) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            if (!agree && ripe) begin
                level_reg <= sync2_reg;
            end
        end
    end

    assign level = level_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_spike_rejected;
        @(posedge ref_clk) disable iff (srst)
        $changed(level_reg) |-> ($past(sync2_reg, 2) == level_reg)
                              && ($past(sync2_reg, 1) == level_reg);
    endproperty
    a_spike_rejected: assert property (p_spike_rejected)
        else $error("filter output moved on a short spike");

endmodule // glitch_filter

// File: design/dac_setting_i2c_slave_por.sv
// Purpose: Power-up handling and two-wire slave port of the output setting
// Assumes: srst comes from the supply trip detector; pins are asynchronous
// Notes:   Slave only; SCL is input only; SDA is open drain
//
// Contract
// - Supply rise loads shift 40h, setting 20h
// - After default load, enable serial port
// - Supply drop disables port, ignores bus
// - Below retention, setting marked possibly corrupt
// - Brown-out may lose a partial write
// - Seven-bit setting reloaded on every rise
// - Stop enters static state, start leaves
// - Port writes and reads the setting
// - Slave only, seven-bit addressing
// - Works up to 100 and 400 kb/s
// - Lines only pulled low or released
// - Spikes on clock and data suppressed
// - Data fall while clock high starts
// - Data changes only while clock low
// - Data rise while clock high stops
// - Acknowledge low during the ninth clock
`timescale 1ns/10ps
`include "dac_setting_defines.svh"
module dac_setting_i2c_slave_por
    import dac_setting_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT,
    parameter int         SPIKE_LEN  = `SPIKE_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        supply_drop_reset,
    input  wire logic        retention_lost,
    output logic             sda_out,
    output logic             sda_oe_n,
    output logic [6:0]       output_level_setting,
    output logic             iface_enabled,
    output logic             bus_static,
    output logic             setting_valid
);

    // Filter must settle well inside the shortest clock-high phase
    if (SPIKE_LEN < 2 || SPIKE_LEN * 4 > `FAST_BIT_CYCLES) begin : g_bad_spike
        $error("dac_setting_i2c_slave_por: SPIKE_LEN out of range");
    end

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------
    logic scl_f;
    logic sda_f;
    logic drop_s;
    logic ram_s;

    glitch_filter #(.LEN(SPIKE_LEN), .INIT(1'b1)) u_scl_filt (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin     (scl_in),
        .level   (scl_f)
    );
    glitch_filter #(.LEN(SPIKE_LEN), .INIT(1'b1)) u_sda_filt (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin     (sda_in),
        .level   (sda_f)
    );
    glitch_filter #(.LEN(2), .INIT(1'b1)) u_drop_filt (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin     (supply_drop_reset),
        .level   (drop_s)
    );
    glitch_filter #(.LEN(2), .INIT(1'b0)) u_ram_filt (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin     (retention_lost),
        .level   (ram_s)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    bus_state_type state_reg;
    bus_state_type state_next;
    logic [7:0]    shift_reg;
    logic [7:0]    shift_next;
    logic [6:0]    setting_reg;
    logic [6:0]    setting_next;
    logic [3:0]    cnt_reg;
    logic [3:0]    cnt_next;
    logic          oe_n_reg;
    logic          oe_n_next;
    logic          static_reg;
    logic          static_next;
    logic          rd_reg;
    logic          rd_next;
    logic          cmd_ok_reg;
    logic          cmd_ok_next;
    logic          scl_q;
    logic          sda_q;
    logic          drop_q;
    logic          enabled_reg;
    logic          valid_reg;
    logic          sda_out_reg;

    // ----------------------------------------
    // Event decode
    // ----------------------------------------
    wire       scl_rise    = scl_f & ~scl_q;
    wire       scl_fall    = ~scl_f & scl_q;
    wire       start_det   = scl_f & scl_q & sda_q & ~sda_f;
    wire       stop_det    = scl_f & scl_q & ~sda_q & sda_f;
    wire       supply_rise = drop_q & ~drop_s;
    wire       byte_done   = (cnt_reg == `BYTE_BITS);
    wire       addr_match  = (shift_reg[7:1] == SLAVE_ADDR);
    wire       receiving   = (state_reg == BUS_ADDR) || (state_reg == BUS_CMD)
                           || (state_reg == BUS_WDATA);
    wire [7:0] read_word   = {1'b0, setting_reg};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_next   = state_reg;
        shift_next   = shift_reg;
        setting_next = setting_reg;
        cnt_next     = cnt_reg;
        oe_n_next    = oe_n_reg;
        static_next  = static_reg;
        rd_next      = rd_reg;
        cmd_ok_next  = cmd_ok_reg;
        if (drop_s || supply_rise) begin
            // Partial writes are simply dropped here
            state_next = BUS_IDLE;
            cnt_next   = 4'h0;
            oe_n_next  = 1'b1;
            if (supply_rise) begin
                shift_next   = `SHIFT_DEFAULT;
                setting_next = `SETTING_DEFAULT;
            end
        end else if (start_det) begin
            state_next  = BUS_ADDR;
            cnt_next    = 4'h0;
            oe_n_next   = 1'b1;
            static_next = 1'b0;
        end else if (stop_det) begin
            state_next  = BUS_IDLE;
            oe_n_next   = 1'b1;
            static_next = 1'b1;
        end else if (scl_rise) begin
            if (receiving && !byte_done) begin
                shift_next = {shift_reg[6:0], sda_f};
                cnt_next   = cnt_reg + 4'h1;
            end else if (state_reg == BUS_RDATA_ACK && sda_f) begin
                state_next = BUS_IGNORE;
            end
        end else if (scl_fall) begin
            case (state_reg)
                BUS_ADDR: begin
                    if (byte_done) begin
                        if (addr_match) begin
                            oe_n_next  = 1'b0;
                            rd_next    = shift_reg[0];
                            state_next = BUS_ADDR_ACK;
                        end else begin
                            state_next = BUS_IGNORE;
                        end
                    end
                end
                BUS_CMD: begin
                    if (byte_done) begin
                        oe_n_next   = 1'b0;
                        cmd_ok_next = (shift_reg == `CMD_SETTING);
                        state_next  = BUS_CMD_ACK;
                    end
                end
                BUS_WDATA: begin
                    if (byte_done) begin
                        oe_n_next  = 1'b0;
                        state_next = BUS_WDATA_ACK;
                        if (cmd_ok_reg) begin
                            setting_next = shift_reg[6:0];
                        end
                    end
                end
                BUS_ADDR_ACK, BUS_RDATA_ACK: begin
                    cnt_next = 4'h0;
                    if (rd_reg) begin
                        oe_n_next  = read_word[7];
                        shift_next = {read_word[6:0], 1'b0};
                        cnt_next   = 4'h1;
                        state_next = BUS_RDATA;
                    end else begin
                        oe_n_next  = 1'b1;
                        state_next = BUS_CMD;
                    end
                end
                BUS_CMD_ACK, BUS_WDATA_ACK: begin
                    oe_n_next  = 1'b1;
                    cnt_next   = 4'h0;
                    state_next = BUS_WDATA;
                end
                BUS_RDATA: begin
                    if (byte_done) begin
                        oe_n_next  = 1'b1;
                        state_next = BUS_RDATA_ACK;
                    end else begin
                        oe_n_next  = shift_reg[7];
                        shift_next = {shift_reg[6:0], 1'b0};
                        cnt_next   = cnt_reg + 4'h1;
                    end
                end
                default: begin
                    oe_n_next = 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg   <= BUS_IDLE;
            shift_reg   <= `SHIFT_DEFAULT;
            setting_reg <= `SETTING_DEFAULT;
            cnt_reg     <= 4'h0;
            oe_n_reg    <= 1'b1;
            static_reg  <= 1'b1;
            rd_reg      <= 1'b0;
            cmd_ok_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            shift_reg   <= shift_next;
            setting_reg <= setting_next;
            cnt_reg     <= cnt_next;
            oe_n_reg    <= oe_n_next;
            static_reg  <= static_next;
            rd_reg      <= rd_next;
            cmd_ok_reg  <= cmd_ok_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scl_q       <= 1'b1;
            sda_q       <= 1'b1;
            drop_q      <= 1'b1;
            enabled_reg <= 1'b0;
            valid_reg   <= 1'b1;
            sda_out_reg <= 1'b0;
        end else begin
            scl_q       <= scl_f;
            sda_q       <= sda_f;
            drop_q      <= drop_s;
            enabled_reg <= ~drop_s;
            valid_reg   <= ~ram_s & (valid_reg | supply_rise);
            sda_out_reg <= 1'b0;
        end
    end

    assign sda_out              = sda_out_reg;
    assign sda_oe_n             = oe_n_reg;
    assign output_level_setting = setting_reg;
    assign iface_enabled        = enabled_reg;
    assign bus_static           = static_reg;
    assign setting_valid        = valid_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_addr_hit;
        (state_reg == BUS_ADDR) && byte_done && addr_match && scl_fall
        && !drop_s && !supply_rise && !start_det && !stop_det;
    endsequence

    property p_default_load;
        @(posedge ref_clk) disable iff (srst)
        $fell(drop_s) |=> (setting_reg == `SETTING_DEFAULT)
                         && (shift_reg == `SHIFT_DEFAULT);
    endproperty
    a_default_load: assert property (p_default_load)
        else $error("defaults not loaded on supply rise");

    property p_enable_after_load;
        @(posedge ref_clk) disable iff (srst)
        $fell(drop_s) |=> iface_enabled ##1 iface_enabled;
    endproperty
    a_enable_after_load: assert property (p_enable_after_load)
        else $error("port not enabled after default load");

    property p_drop_disables;
        @(posedge ref_clk) disable iff (srst)
        drop_s |=> !iface_enabled && sda_oe_n && (state_reg == BUS_IDLE);
    endproperty
    a_drop_disables: assert property (p_drop_disables)
        else $error("port active during supply drop");

    property p_retention;
        @(posedge ref_clk) disable iff (srst)
        ram_s |=> !setting_valid;
    endproperty
    a_retention: assert property (p_retention)
        else $error("setting valid after retention loss");

    property p_static;
        @(posedge ref_clk) disable iff (srst)
        !drop_s && !supply_rise && (start_det || stop_det)
            |=> (bus_static == $past(stop_det));
    endproperty
    a_static: assert property (p_static)
        else $error("static state wrong after start or stop");

    property p_ack_ninth;
        @(posedge ref_clk) disable iff (srst)
        s_addr_hit |=> !sda_oe_n && (state_reg == BUS_ADDR_ACK);
    endproperty
    a_ack_ninth: assert property (p_ack_ninth)
        else $error("address acknowledge missing");

    property p_drive_scl_low;
        @(posedge ref_clk) disable iff (srst)
        $fell(sda_oe_n) |-> !scl_f;
    endproperty
    a_drive_scl_low: assert property (p_drive_scl_low)
        else $error("data driven while clock high");

    property p_only_low;
        @(posedge ref_clk) disable iff (srst)
        !sda_out;
    endproperty
    a_only_low: assert property (p_only_low)
        else $error("data line driven high");

    property p_write_lands;
        @(posedge ref_clk) disable iff (srst)
        (state_reg == BUS_WDATA) && byte_done && scl_fall && cmd_ok_reg
        && !drop_s && !supply_rise && !start_det && !stop_det
            |=> (output_level_setting == $past(shift_reg[6:0]));
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("setting not written");

endmodule // dac_setting_i2c_slave_por

// File: tb/i2c_master_model.sv
// Purpose: Behavioural two-wire bus master that drives the serial port
// Assumes: Open-drain lines with pull-ups resolved by the bench
// Notes:   Times counted in ref_clk cycles, lines change at the falling edge
`timescale 1ns/10ps
module i2c_master_model #(
    parameter int HALF = 63
) (
    input  wire logic ref_clk,
    input  wire logic sda_wire,
    output logic      scl_low,
    output logic      sda_low
);
    // ----------------------------------------
    // Line drivers, released at start
    // ----------------------------------------
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // ----------------------------------------
    // Conditions
    // ----------------------------------------
    task automatic start_cond;
        sda_low = 1'b0;
        wait_cyc(HALF);
        scl_low = 1'b0;
        wait_cyc(HALF);
        sda_low = 1'b1;
        wait_cyc(HALF);
        scl_low = 1'b1;
    endtask

    task automatic stop_cond;
        wait_cyc(2);
        sda_low = 1'b1;
        wait_cyc(HALF);
        scl_low = 1'b0;
        wait_cyc(HALF);
        sda_low = 1'b0;
        wait_cyc(HALF);
    endtask

    task automatic spike(input int n);
        sda_low = 1'b1;
        wait_cyc(n);
        sda_low = 1'b0;
    endtask

    // ----------------------------------------
    // Bits and bytes, MSB first
    // ----------------------------------------
    task automatic bit_io(input logic b, output logic r);
        wait_cyc(2);
        sda_low = ~b;
        wait_cyc(HALF - 2);
        scl_low = 1'b0;
        wait_cyc(HALF - 1);
        r = sda_wire;
        wait_cyc(1);
        scl_low = 1'b1;
    endtask

    task automatic xfer_byte(input logic [7:0] tx, input logic ack_bit,
                             output logic [7:0] rx, output logic ack_seen);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_bit, ack_seen);
    endtask
endmodule // i2c_master_model

// File: tb/dac_setting_i2c_slave_por_bench.sv
// Purpose: Self-checking bench for the setting port and its power-up handling
// Assumes: Master model on the far side, pull-ups on both lines
// Notes:   Bit phases kept at the port's minimum high and low time
`timescale 1ns/10ps
`include "dac_setting_defines.svh"
module dac_setting_i2c_slave_por_bench;
    localparam logic [6:0] ADDR = 7'h2E;

    logic       ref_clk;
    logic       srst;
    logic       supply_drop_reset;
    logic       retention_lost;
    logic       scl_low;
    logic       sda_low;
    logic       scl_wire;
    logic       sda_wire;
    logic       sda_out;
    logic       sda_oe_n;
    logic [6:0] output_level_setting;
    logic       iface_enabled;
    logic       bus_static;
    logic       setting_valid;
    int         fails;
    int         tests_run;

    // ----------------------------------------
    // Wired-AND of both lines with pull-ups
    // ----------------------------------------
    assign scl_wire = scl_low ? 1'b0 : 1'b1;
    assign sda_wire = sda_low ? 1'b0 : ((sda_oe_n === 1'b0) ? sda_out : 1'b1);

    dac_setting_i2c_slave_por dut (
        .ref_clk             (ref_clk),
        .srst                (srst),
        .scl_in              (scl_wire),
        .sda_in              (sda_wire),
        .supply_drop_reset   (supply_drop_reset),
        .retention_lost      (retention_lost),
        .sda_out             (sda_out),
        .sda_oe_n            (sda_oe_n),
        .output_level_setting(output_level_setting),
        .iface_enabled       (iface_enabled),
        .bus_static          (bus_static),
        .setting_valid       (setting_valid)
    );

    i2c_master_model m (
        .ref_clk (ref_clk),
        .sda_wire(sda_wire),
        .scl_low (scl_low),
        .sda_low (sda_low)
    );

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wait_enabled;
        int i;
        for (i = 0; i < 40; i++) begin
            if (iface_enabled === 1'b1) break;
            @(negedge ref_clk);
        end
        if (i == 40) begin
            fails++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a8, input logic [7:0] cmd,
                      input logic [7:0] dat, output logic [2:0] ak);
        logic [7:0] rx;
        m.start_cond();
        m.xfer_byte(a8, 1'b1, rx, ak[2]);
        m.xfer_byte(cmd, 1'b1, rx, ak[1]);
        m.xfer_byte(dat, 1'b1, rx, ak[0]);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_after_reset;
        check({1'b0, output_level_setting}, {1'b0, `SETTING_DEFAULT});
        check({7'h00, sda_oe_n}, 8'h01);
        check({7'h00, bus_static}, 8'h01);
        check({7'h00, setting_valid}, 8'h01);
        check({7'h00, sda_out}, 8'h00);
        check({7'h00, iface_enabled}, 8'h00);
        wait_enabled();
        check({7'h00, iface_enabled}, 8'h01);
    endtask

    task automatic t_write;
        logic [2:0] ak;
        wr({ADDR, 1'b0}, `CMD_SETTING, 8'hD5, ak);
        check({5'h00, ak}, 8'h00);
        check({7'h00, bus_static}, 8'h00);
        check({1'b0, output_level_setting}, 8'h55);
        m.stop_cond();
        check({7'h00, bus_static}, 8'h01);
        check({7'h00, sda_oe_n}, 8'h01);
    endtask

    task automatic t_read;
        logic [7:0] rx;
        logic       a;
        m.start_cond();
        m.xfer_byte({ADDR, 1'b0}, 1'b1, rx, a);
        m.xfer_byte(`CMD_SETTING, 1'b1, rx, a);
        m.start_cond();
        m.xfer_byte({ADDR, 1'b1}, 1'b1, rx, a);
        check({7'h00, a}, 8'h00);
        m.xfer_byte(8'hFF, 1'b0, rx, a);
        check(rx, 8'h55);
        m.xfer_byte(8'hFF, 1'b1, rx, a);
        check(rx, 8'h55);
        m.stop_cond();
        check({7'h00, sda_oe_n}, 8'h01);
    endtask

    task automatic t_refused;
        logic [2:0] ak;
        wr({ADDR ^ 7'h01, 1'b0}, `CMD_SETTING, 8'h11, ak);
        m.stop_cond();
        check({7'h00, ak[2]}, 8'h01);
        check({1'b0, output_level_setting}, 8'h55);
        wr({ADDR, 1'b0}, 8'h01, 8'h11, ak);
        m.stop_cond();
        check({5'h00, ak}, 8'h00);
        check({1'b0, output_level_setting}, 8'h55);
    endtask

    task automatic t_spike;
        m.spike(2);
        m.wait_cyc(20);
        check({7'h00, bus_static}, 8'h01);
        check({7'h00, sda_oe_n}, 8'h01);
    endtask

    task automatic t_drop;
        logic [2:0] ak;
        supply_drop_reset = 1'b1;
        m.wait_cyc(10);
        check({7'h00, iface_enabled}, 8'h00);
        wr({ADDR, 1'b0}, `CMD_SETTING, 8'h0A, ak);
        m.stop_cond();
        check({7'h00, ak[2]}, 8'h01);
        check({1'b0, output_level_setting}, 8'h55);
        retention_lost = 1'b1;
        m.wait_cyc(10);
        check({7'h00, setting_valid}, 8'h00);
        retention_lost = 1'b0;
        supply_drop_reset = 1'b0;
        wait_enabled();
        m.wait_cyc(4);
        check({1'b0, output_level_setting}, {1'b0, `SETTING_DEFAULT});
        check({7'h00, setting_valid}, 8'h01);
        check({7'h00, bus_static}, 8'h01);
        wr({ADDR, 1'b0}, `CMD_SETTING, 8'h3A, ak);
        m.stop_cond();
        check({1'b0, output_level_setting}, 8'h3A);
    endtask

    task automatic t_reset_mid;
        logic [7:0] rx;
        logic       a;
        logic [2:0] ak;
        m.start_cond();
        m.xfer_byte({ADDR, 1'b0}, 1'b1, rx, a);
        check({7'h00, bus_static}, 8'h00);
        check({7'h00, sda_oe_n}, 8'h00);
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        check({1'b0, output_level_setting}, {1'b0, `SETTING_DEFAULT});
        check({7'h00, bus_static}, 8'h01);
        check({7'h00, sda_oe_n}, 8'h01);
        wait_enabled();
        m.stop_cond();
        wr({ADDR, 1'b0}, `CMD_SETTING, 8'h2B, ak);
        m.stop_cond();
        check({5'h00, ak}, 8'h00);
        check({1'b0, output_level_setting}, 8'h2B);
    endtask

    // ----------------------------------------
    // Clock, reset and main sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        fails = 0;
        tests_run = 0;
        srst = 1'b1;
        supply_drop_reset = 1'b0;
        retention_lost = 1'b0;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        t_after_reset();
        m.wait_cyc(12);
        t_write();
        t_read();
        t_refused();
        t_spike();
        t_drop();
        t_reset_mid();
        conclude();
    end
endmodule // dac_setting_i2c_slave_por_bench
